//--- rtl/tpr_top.sv
// Timer counter with posted and non-posted register-read synchronisation
`default_nettype none

// Contract
// - Control bit 2 set selects posted mode; clear selects non-posted mode.
// - Posted reads after interface clock restart may return stale shadow values.
// - Non-posted reads after interface clock restart always return correct values.
// - Instances 1, 2, 10: read-mode bit write-only, reads back zero.
module tpr_top #(
  parameter int INSTANCE_NUM = 0
) (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic                        iface_clk_active,
  input  wire logic                        capture_one,
  input  wire logic                        capture_two,
  input  wire logic                        ctrl_wr_en,
  input  wire logic [tpr_pkg::CTRL_W-1:0]  ctrl_wr_data,
  input  wire logic                        rd_req,
  input  wire logic [1:0]                  rd_sel,
  output var  logic [tpr_pkg::CTRL_W-1:0]  ctrl_rdata,
  output var  logic                        rd_busy,
  output var  logic                        rd_valid,
  output var  logic [tpr_pkg::DATA_W-1:0]  rd_data
);
  import tpr_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [2:0]         sync1_q;
  logic [2:0]         sync2_q;
  logic [2:0]         sync3_q;
  logic [DIV_W-1:0]   div_q;
  logic               tick_q;
  logic [DATA_W-1:0]  counter_value_q;
  logic [DATA_W-1:0]  capture_value_one_q;
  logic [DATA_W-1:0]  capture_value_two_q;
  logic [CTRL_W-1:0]  sync_interface_ctrl_q;
  logic [SNAP_W-1:0]  shadow_q;
  logic               shadow_fresh_q;
  tpr_rd_state_t      rd_state_q;
  logic               fresh_kind_q;
  logic               req_fresh_q;
  logic               armed_q;
  logic [1:0]         sel_q;
  logic               rd_valid_q;
  logic [DATA_W-1:0]  rd_data_q;
  logic               rd_busy_q;
  logic [CTRL_W-1:0]  ctrl_rdata_q;

  wire                iface_act;
  wire                act_rise;
  wire                cap_one_rise;
  wire                cap_two_rise;
  wire                posted_mode;
  wire                rdmode_bit;
  wire                accurate_rd;
  wire                wo_inst;
  wire [CTRL_W-1:0]   ctrl_view;
  wire [SNAP_W-1:0]   live_snap;
  wire                rs_busy;
  wire                rs_done;
  wire [SNAP_W-1:0]   rs_data;
  wire                rs_start;
  wire                take_rd;
  wire                answer_now;
  wire [SNAP_W-1:0]   ans_src;
  wire [DATA_W-1:0]   ans_word;
  wire [DATA_W-1:0]   posted_word;

  // ----------------------------------------------------------------
  // Decoding and selection
  // ----------------------------------------------------------------
  // Synchronised pins and edges
  assign iface_act    = sync2_q[0];
  assign act_rise     = sync2_q[0] & ~sync3_q[0];
  assign cap_one_rise = sync2_q[1] & ~sync3_q[1];
  assign cap_two_rise = sync2_q[2] & ~sync3_q[2];

  // Mode decode
  assign posted_mode  = sync_interface_ctrl_q[CTRL_POSTED_BIT];
  assign rdmode_bit   = sync_interface_ctrl_q[CTRL_RDMODE_BIT];
  assign accurate_rd  = ~posted_mode & rdmode_bit;

  // Write-only read-mode bit on selected instances
  assign wo_inst   = (INSTANCE_NUM == WO_INST_A) || (INSTANCE_NUM == WO_INST_B)
                   || (INSTANCE_NUM == WO_INST_C);
  assign ctrl_view = wo_inst
                   ? (sync_interface_ctrl_q & ~(CTRL_W'(1) << CTRL_RDMODE_BIT))
                   : sync_interface_ctrl_q;

  // Live functional values
  assign live_snap = {capture_value_two_q, capture_value_one_q, counter_value_q};

  // Resync arbitration: fresh requests first, else background refresh
  assign rs_start = ~rs_busy & (req_fresh_q | iface_act);

  // Read sequencing
  assign take_rd     = rd_req & (rd_state_q == RD_IDLE);
  assign answer_now  = (rd_state_q == RD_WAIT)
                     & (fresh_kind_q ? (rs_done & armed_q)
                                     : shadow_fresh_q);
  assign ans_src     = fresh_kind_q ? rs_data : shadow_q;
  assign ans_word    = (sel_q == SEL_COUNTER) ? ans_src[0 +: DATA_W]
                     : (sel_q == SEL_CAP_ONE) ? ans_src[DATA_W +: DATA_W]
                     : (sel_q == SEL_CAP_TWO) ? ans_src[2*DATA_W +: DATA_W]
                     : '0;
  // Posted reads take the shadow as is, stale or not
  assign posted_word = (rd_sel == SEL_COUNTER) ? shadow_q[0 +: DATA_W]
                     : (rd_sel == SEL_CAP_ONE) ? shadow_q[DATA_W +: DATA_W]
                     : (rd_sel == SEL_CAP_TWO) ? shadow_q[2*DATA_W +: DATA_W]
                     : '0;

  assign ctrl_rdata = ctrl_rdata_q;
  assign rd_busy    = rd_busy_q;
  assign rd_valid   = rd_valid_q;
  assign rd_data    = rd_data_q;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end
    else
    begin
      sync1_q <= {capture_two, capture_one, iface_clk_active};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // ----------------------------------------------------------------
  // Functional domain: tick divider, counter, captures
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (div_q == FUNC_DIV_LAST);
      div_q  <= (div_q == FUNC_DIV_LAST) ? '0 : div_q + 1'b1;
    end
  end

  // Counter advances on ticks; captures latch on pin edges
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      counter_value_q     <= '0;
      capture_value_one_q <= '0;
      capture_value_two_q <= '0;
    end
    else
    begin
      if (tick_q)
        counter_value_q <= counter_value_q + 1'b1;
      if (cap_one_rise)
        capture_value_one_q <= counter_value_q;
      if (cap_two_rise)
        capture_value_two_q <= counter_value_q;
    end
  end

  // ----------------------------------------------------------------
  // Control word and its read view
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync_interface_ctrl_q <= CTRL_RESET;
      ctrl_rdata_q          <= CTRL_RESET;
    end
    else
    begin
      if (ctrl_wr_en)
        sync_interface_ctrl_q <= ctrl_wr_data;
      ctrl_rdata_q <= ctrl_view;
    end
  end

  // ----------------------------------------------------------------
  // Resync stage
  // ----------------------------------------------------------------
  tpr_resync #(
    .WIDTH (SNAP_W)
  ) u_resync (
    .clk       (clk),
    .resetn    (resetn),
    .func_tick (tick_q),
    .start     (rs_start),
    .src       (live_snap),
    .busy      (rs_busy),
    .done      (rs_done),
    .data      (rs_data)
  );

  // Shadow copy; stale after the interface clock stops or restarts
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      shadow_q       <= '0;
      shadow_fresh_q <= 1'b0;
    end
    else
    begin
      if (rs_done)
        shadow_q <= rs_data;
      if (!iface_act || act_rise)
        shadow_fresh_q <= 1'b0;
      else if (rs_done)
        shadow_fresh_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_state_q   <= RD_IDLE;
      fresh_kind_q <= 1'b0;
      req_fresh_q  <= 1'b0;
      armed_q      <= 1'b0;
      sel_q        <= SEL_COUNTER;
      rd_valid_q   <= 1'b0;
      rd_data_q    <= '0;
      rd_busy_q    <= 1'b0;
    end
    else
    begin
      rd_valid_q <= 1'b0;
      if (rs_start && req_fresh_q)
      begin
        req_fresh_q <= 1'b0;
        armed_q     <= 1'b1;
      end
      unique case (rd_state_q)
        RD_IDLE:
        begin
          if (take_rd && posted_mode)
          begin
            rd_valid_q <= 1'b1;
            rd_data_q  <= posted_word;
          end
          else if (take_rd)
          begin
            sel_q        <= rd_sel;
            fresh_kind_q <= accurate_rd;
            req_fresh_q  <= accurate_rd;
            rd_busy_q    <= 1'b1;
            rd_state_q   <= RD_WAIT;
          end
        end
        RD_WAIT:
        begin
          if (answer_now)
          begin
            rd_valid_q <= 1'b1;
            rd_data_q  <= ans_word;
            rd_busy_q  <= 1'b0;
            armed_q    <= 1'b0;
            rd_state_q <= RD_IDLE;
          end
        end
        default:
          rd_state_q <= RD_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

//--- rtl/tpr_pkg.sv
// Constants and types for the timer register-read synchronisation path
`default_nettype none

package tpr_pkg;

  // ----------------------------------------------------------------
  // Data and control layout
  // ----------------------------------------------------------------
  localparam int        DATA_W           = 32;
  localparam int        SNAP_W           = 3 * DATA_W;
  localparam int        CTRL_W           = 4;
  localparam int        CTRL_POSTED_BIT  = 2;
  localparam int        CTRL_RDMODE_BIT  = 3;
  localparam logic [3:0] CTRL_RESET      = 4'h0;

  // Read selection codes
  localparam logic [1:0] SEL_COUNTER     = 2'h0;
  localparam logic [1:0] SEL_CAP_ONE     = 2'h1;
  localparam logic [1:0] SEL_CAP_TWO     = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  // Functional tick every FUNC_DIV_LAST + 1 (4) clocks
  localparam int         DIV_W           = 8;
  localparam logic [7:0] FUNC_DIV_LAST   = 8'h03;
  // Settling cycles after a functional-domain sample
  localparam int         SETTLE_W        = 2;
  localparam logic [1:0] SETTLE_LAST     = 2'h1;

  // Instances whose read-mode bit is write-only
  localparam int        WO_INST_A        = 1;
  localparam int        WO_INST_B        = 2;
  localparam int        WO_INST_C        = 10;

  // Read sequencer states
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_WAIT = 2'b10
  } tpr_rd_state_t;

  // Resync stage states
  typedef enum logic [2:0] {
    RS_IDLE   = 3'b001,
    RS_TICK   = 3'b010,
    RS_SETTLE = 3'b100
  } tpr_rs_state_t;

endpackage

`default_nettype wire

//--- rtl/tpr_resync.sv
// Snapshot stage carrying functional-domain values to the interface side
`default_nettype none

module tpr_resync #(
  parameter int WIDTH = 96
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             func_tick,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] src,
  output var  logic             busy,
  output var  logic             done,
  output var  logic [WIDTH-1:0] data
);
  import tpr_pkg::*;

  tpr_rs_state_t               state_q;
  logic [SETTLE_W-1:0]         cnt_q;
  logic [WIDTH-1:0]            data_q;
  logic                        done_q;

  assign busy = (state_q != RS_IDLE);
  assign done = done_q;
  assign data = data_q;

  // ----------------------------------------------------------------
  // Sample on a functional tick, then settle before reporting
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= RS_IDLE;
      cnt_q   <= '0;
      data_q  <= '0;
      done_q  <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      unique case (state_q)
        RS_IDLE:
        begin
          if (start)
            state_q <= RS_TICK;
        end
        RS_TICK:
        begin
          if (func_tick)
          begin
            data_q  <= src;
            cnt_q   <= SETTLE_LAST;
            state_q <= RS_SETTLE;
          end
        end
        RS_SETTLE:
        begin
          if (cnt_q == '0)
          begin
            done_q  <= 1'b1;
            state_q <= RS_IDLE;
          end
          else
            cnt_q <= cnt_q - 1'b1;
        end
        default:
          state_q <= RS_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

//--- bench/tpr_top_monitor.sv
// Concurrent checks on the timer read synchronisation ports
`default_nettype none

module tpr_top_monitor
  import tpr_pkg::*;
#(
  parameter int INSTANCE_NUM = 0
) (
  input wire logic                       clk,
  input wire logic                       resetn,
  input wire logic                       iface_clk_active,
  input wire logic                       capture_one,
  input wire logic                       capture_two,
  input wire logic                       ctrl_wr_en,
  input wire logic [tpr_pkg::CTRL_W-1:0] ctrl_wr_data,
  input wire logic                       rd_req,
  input wire logic [1:0]                 rd_sel,
  input wire logic [tpr_pkg::CTRL_W-1:0] ctrl_rdata,
  input wire logic                       rd_busy,
  input wire logic                       rd_valid,
  input wire logic [tpr_pkg::DATA_W-1:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------
  // Helpers
  // ------
  localparam bit WO = INSTANCE_NUM inside {WO_INST_A, WO_INST_B, WO_INST_C};
  localparam logic [3:0] VIS = WO ? 4'h7 : 4'hF;
  logic [3:0] mode_q;
  wire logic  take  = rd_req && !rd_busy && !rd_valid;
  wire logic  exact = take && mode_q[3:2] == 2'h2;

  // Control word as the read path sees it
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      mode_q <= CTRL_RESET;
    else if (ctrl_wr_en)
      mode_q <= ctrl_wr_data;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Read timing by mode
  a_posted_next_edge: assert property (take && mode_q[2] |=> rd_valid && !rd_busy)
    else $error("posted read late");
  a_nonposted_busy: assert property (take && !mode_q[2] |=> rd_busy && !rd_valid)
    else $error("non-posted read not held");
  a_exact_fresh_sample: assert property (exact |=> !rd_valid [*2])
    else $error("accurate read answered too soon");
  a_exact_bounded: assert property (exact && iface_clk_active |-> ##[3:20] rd_valid)
    else $error("accurate read never answered");
  a_busy_ends_answer: assert property ($fell(rd_busy) |-> rd_valid)
    else $error("busy dropped without answer");
  a_data_holds: assert property (!rd_valid |-> $stable(rd_data))
    else $error("read data moved without answer");
  // Control view
  a_ctrl_view: assert property (ctrl_wr_en |-> ##2
    ctrl_rdata == ($past(ctrl_wr_data, 2) & VIS))
    else $error("control view wrong");
  a_ctrl_stands: assert property (!$past(ctrl_wr_en, 2) |-> $stable(ctrl_rdata))
    else $error("control view moved");
  a_mode_bit_hidden: assert property (WO |-> !ctrl_rdata[3])
    else $error("write-only bit visible");
endmodule

bind tpr_top tpr_top_monitor #(.INSTANCE_NUM(INSTANCE_NUM)) i_tpr_top_monitor (
  .clk(clk), .resetn(resetn), .iface_clk_active(iface_clk_active),
  .capture_one(capture_one), .capture_two(capture_two), .ctrl_wr_en(ctrl_wr_en),
  .ctrl_wr_data(ctrl_wr_data), .rd_req(rd_req), .rd_sel(rd_sel), .ctrl_rdata(ctrl_rdata),
  .rd_busy(rd_busy), .rd_valid(rd_valid), .rd_data(rd_data)
);

`default_nettype wire

//--- bench/tpr_host.sv
// Processor-side model issuing control writes and register reads
`default_nettype none

module tpr_host (
  input  wire logic                       clk,
  input  wire logic                       rd_valid,
  input  wire logic [tpr_pkg::DATA_W-1:0] rd_data,
  output var  logic                       ctrl_wr_en,
  output var  logic [tpr_pkg::CTRL_W-1:0] ctrl_wr_data,
  output var  logic                       rd_req,
  output var  logic [1:0]                 rd_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------
  // Bus cycles
  // ------
  // Idle levels at time zero
  initial
  begin
    ctrl_wr_en   = 1'b0;
    ctrl_wr_data = 4'h0;
    rd_req       = 1'b0;
    rd_sel       = 2'h3;
  end

  // One-cycle control strobe, data inverted after release
  task automatic wr_ctrl(input logic [3:0] d);
    @(negedge clk);
    ctrl_wr_en   = 1'b1;
    ctrl_wr_data = d;
    @(negedge clk);
    ctrl_wr_en   = 1'b0;
    ctrl_wr_data = ~d;
  endtask

  // One request pulse, bounded wait for the answer
  task automatic rd(input logic [1:0] s, output logic [31:0] v, output bit ok);
    @(negedge clk);
    rd_req = 1'b1;
    rd_sel = s;
    @(negedge clk);
    rd_req = 1'b0;
    rd_sel = ~s;
    // A posted answer stands only in the cycle after the request edge
    ok     = (rd_valid === 1'b1);
    for (int n = 0; n < 40 && !ok; n++)
    begin
      @(negedge clk);
      ok = (rd_valid === 1'b1);
    end
    v = rd_data;
  endtask
endmodule

`default_nettype wire

//--- bench/timer_posted_read_sync_tb.sv
// Self-checking bench for the timer read synchronisation path
`default_nettype none

module timer_posted_read_sync_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tpr_pkg::*;
  // ------
  // Signals and model state
  // ------
  logic              clk, resetn, iface_clk_active, capture_one, capture_two;
  logic              ctrl_wr_en, rd_req, rd_busy, rd_valid;
  logic [CTRL_W-1:0] ctrl_wr_data, ctrl_rdata, wo_rdata;
  logic [1:0]        rd_sel;
  logic [DATA_W-1:0] v, lfsr_q, rd_data;
  logic signed [32:0] sv;
  bit                ok;
  int                miscompares, checked, cyc, cap1, cap2;
  logic [3:0]        modes [4] = '{4'h4, 4'h0, 4'h8, 4'hC};

  tpr_top #(.INSTANCE_NUM(0)) i_tpr_top (
    .clk(clk), .resetn(resetn), .iface_clk_active(iface_clk_active),
    .capture_one(capture_one), .capture_two(capture_two), .ctrl_wr_en(ctrl_wr_en),
    .ctrl_wr_data(ctrl_wr_data), .rd_req(rd_req), .rd_sel(rd_sel), .ctrl_rdata(ctrl_rdata),
    .rd_busy(rd_busy), .rd_valid(rd_valid), .rd_data(rd_data)
  );
  tpr_top #(.INSTANCE_NUM(10)) i_tpr_top_wo (
    .clk(clk), .resetn(resetn), .iface_clk_active(iface_clk_active),
    .capture_one(capture_one), .capture_two(capture_two), .ctrl_wr_en(ctrl_wr_en),
    .ctrl_wr_data(ctrl_wr_data), .rd_req(rd_req), .rd_sel(rd_sel), .ctrl_rdata(wo_rdata),
    .rd_busy(), .rd_valid(), .rd_data()
  );
  tpr_host i_tpr_host (
    .clk(clk), .rd_valid(rd_valid), .rd_data(rd_data), .ctrl_wr_en(ctrl_wr_en),
    .ctrl_wr_data(ctrl_wr_data), .rd_req(rd_req), .rd_sel(rd_sel)
  );

  // Clock and cycle count since reset, the counter model's time base
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cyc <= 0;
    else
      cyc <= cyc + 1;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input bit c, input string m);
    checked++;
    if (!c)
    begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Read and compare with the tick model: counter lags by at most lag ticks
  task automatic rd_chk(input logic [1:0] s, input int lag);
    int c0, lo, hi;
    c0 = cyc;
    i_tpr_host.rd(s, v, ok);
    if (!ok)
    begin
      chk(1'b0, "read not answered");
      report_and_stop();
    end
    lo = (s == SEL_COUNTER) ? c0 / 4 - lag : (s == SEL_CAP_ONE ? cap1 : cap2) / 4 - 2;
    hi = (s == SEL_COUNTER) ? cyc / 4 + 1 : lo + 3;
    sv = {1'b0, v};
    if (s == 2'h3)
      chk(v === 32'h0, "unused select not zero");
    else
      chk(sv >= lo && sv <= hi, "value outside model range");
  endtask

  // ------
  // Main sequence
  // ------
  initial
  begin
    resetn = 1'b0;
    iface_clk_active = 1'b1;
    capture_one = 1'b0;
    capture_two = 1'b0;
    lfsr_q = 32'hEE11F922;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    chk(rd_busy === 1'b0 && rd_valid === 1'b0 && ctrl_rdata === 4'h0, "reset state");
    // Random control words seen two edges later
    repeat (8)
    begin
      lfsr_q = lfsr(lfsr_q);
      i_tpr_host.wr_ctrl(lfsr_q[3:0]);
      repeat (2) @(negedge clk);
      chk(ctrl_rdata === lfsr_q[3:0], "control readback");
      chk(wo_rdata === (lfsr_q[3:0] & 4'h7), "write-only bit visible");
    end
    // Capture pins latch the running count
    capture_one = 1'b1;
    cap1 = cyc + 3;
    repeat (6) @(negedge clk);
    capture_two = 1'b1;
    cap2 = cyc + 3;
    repeat (6) @(negedge clk);
    // Every mode with every select, interface running
    foreach (modes[m])
    begin
      i_tpr_host.wr_ctrl(modes[m]);
      for (int s = 0; s < 4; s++)
        rd_chk(2'(s), 4);
    end
    // Interface clock stop then restart, read at once
    foreach (modes[m])
    begin
      i_tpr_host.wr_ctrl(modes[m]);
      iface_clk_active = 1'b0;
      repeat (24) @(negedge clk);
      iface_clk_active = 1'b1;
      rd_chk(SEL_COUNTER, modes[m][2] ? 64 : 2);
    end
    // Second reset in mid-run
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    chk(rd_valid === 1'b0 && ctrl_rdata === 4'h0 && rd_data === 32'h0, "second reset");
    rd_chk(SEL_COUNTER, 2);
    report_and_stop();
  end
endmodule

`default_nettype wire
